// >>> shared/imp_consts.svh
// Constants for the integer multiply unit: encodings and timing
`ifndef IMP_CONSTS_SVH
`define IMP_CONSTS_SVH
`define IMP_MAJOR_GROUP_A 6'h00
`define IMP_EXT_FUNC_GROUP 6'h3C
`define IMP_MINOR_WR_BOTTOM 10'h0F5
`define IMP_MINOR_WR_UPPER 10'h0B5
`define IMP_MINOR_PROD_REG 10'h210
`define IMP_MINOR_UNS_WIDE 10'h26C
`define IMP_MINOR_SGN_WIDE 10'h22C
`define IMP_MINOR_RD_UPPER 10'h035
`define IMP_MINOR_RD_BOTTOM 10'h075
`define IMP_MUL_STEPS 5'h10
`define IMP_PROD_RST 32'h0000_0000
`endif

// >>> shared/imp_pkg.sv
// Types for the integer multiply unit
package imp_pkg;
  typedef enum logic [2:0] {
    IMP_OP_NONE = 3'b000,
    IMP_OP_WR_BOTTOM = 3'b001,
    IMP_OP_WR_UPPER = 3'b010,
    IMP_OP_PROD_REG = 3'b011,
    IMP_OP_SGN_WIDE = 3'b100,
    IMP_OP_UNS_WIDE = 3'b101,
    IMP_OP_RD_UPPER = 3'b110,
    IMP_OP_RD_BOTTOM = 3'b111
  } imp_op_t;
  typedef enum logic [1:0] {
    IMP_ST_IDLE = 2'b00,
    IMP_ST_BUSY = 2'b01,
    IMP_ST_DONE = 2'b10
  } imp_state_t;
endpackage

// >>> src/imp_decode.sv
// Instruction word decoder for the integer multiply unit
`include "imp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module imp_decode
  import imp_pkg::*;
(
  input wire logic [31:0] instr,
  output imp_op_t op
);
  logic [5:0] major;
  logic [5:0] func;
  logic [9:0] minor;
  logic top_zero;
  assign major = instr[31:26];
  assign func = instr[5:0];
  assign minor = instr[15:6];
  assign top_zero = (instr[25:21] == 5'h00);
  always_comb begin
    op = IMP_OP_NONE;
    if (major == `IMP_MAJOR_GROUP_A) begin
      if (instr[9:0] == `IMP_MINOR_PROD_REG && !instr[10]) begin
        op = IMP_OP_PROD_REG;
      end else if (func == `IMP_EXT_FUNC_GROUP) begin
        case (minor)
          `IMP_MINOR_WR_BOTTOM: op = top_zero ? IMP_OP_WR_BOTTOM : IMP_OP_NONE;
          `IMP_MINOR_WR_UPPER: op = top_zero ? IMP_OP_WR_UPPER : IMP_OP_NONE;
          `IMP_MINOR_SGN_WIDE: op = IMP_OP_SGN_WIDE;
          `IMP_MINOR_UNS_WIDE: op = IMP_OP_UNS_WIDE;
          `IMP_MINOR_RD_UPPER: op = IMP_OP_RD_UPPER;
          `IMP_MINOR_RD_BOTTOM: op = IMP_OP_RD_BOTTOM;
          default: op = IMP_OP_NONE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> src/imp_mul_unit.sv
// Integer multiply datapath with upper and bottom product registers
`include "imp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module imp_mul_unit
  import imp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic issue_valid,
  input wire logic [31:0] issue_instr,
  input wire logic [31:0] operand_one_val,
  input wire logic [31:0] operand_two_val,
  input wire logic [4:0] check_src_a,
  input wire logic [4:0] check_src_b,
  output logic issue_stall,
  output logic wb_valid,
  output logic [4:0] wb_index,
  output logic [31:0] wb_data,
  output logic [31:0] upper_product_reg,
  output logic [31:0] bottom_product_reg,
  output logic arith_exc
);
  typedef struct packed {
    imp_state_t state;
    logic [4:0] steps;
    logic to_gpr;
    logic [4:0] dest;
    logic [63:0] prod;
    logic [31:0] upper;
    logic [31:0] bottom;
    logic wb_valid;
    logic [4:0] wb_index;
    logic [31:0] wb_data;
    logic stall;
  } imp_regs_t;

  imp_regs_t cur_ff;
  imp_regs_t nxt_cur;
  imp_op_t op;
  logic [63:0] sgn_prod;
  logic [63:0] uns_prod;
  logic busy_nxt;
  logic hazard;

  imp_decode u_dec (
    .instr(issue_instr),
    .op(op)
  );

  assign sgn_prod = 64'($signed(operand_one_val) * $signed(operand_two_val));
  assign uns_prod = {32'h0000_0000, operand_one_val} * {32'h0000_0000, operand_two_val};

  // Stall logic uses the next-state busy flag so the output stays registered
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.wb_valid = 1'b0;
    case (cur_ff.state)
      IMP_ST_IDLE: begin
        if (issue_valid && !cur_ff.stall) begin
          case (op)
            IMP_OP_WR_BOTTOM: nxt_cur.bottom = operand_one_val;
            IMP_OP_WR_UPPER: nxt_cur.upper = operand_one_val;
            IMP_OP_PROD_REG, IMP_OP_SGN_WIDE, IMP_OP_UNS_WIDE: begin
              // Fixed latency; a data-dependent early exit was not worth the area
              nxt_cur.state = IMP_ST_BUSY;
              nxt_cur.steps = `IMP_MUL_STEPS;
              nxt_cur.to_gpr = (op == IMP_OP_PROD_REG);
              nxt_cur.dest = issue_instr[15:11];
              nxt_cur.prod = (op == IMP_OP_UNS_WIDE) ? uns_prod : sgn_prod;
            end
            IMP_OP_RD_UPPER: begin
              nxt_cur.wb_valid = 1'b1;
              nxt_cur.wb_index = issue_instr[25:21];
              nxt_cur.wb_data = cur_ff.upper;
            end
            IMP_OP_RD_BOTTOM: begin
              nxt_cur.wb_valid = 1'b1;
              nxt_cur.wb_index = issue_instr[25:21];
              nxt_cur.wb_data = cur_ff.bottom;
            end
            default: nxt_cur.state = IMP_ST_IDLE;
          endcase
        end
      end
      IMP_ST_BUSY: begin
        nxt_cur.steps = cur_ff.steps - 5'h01;
        if (cur_ff.steps == 5'h01) begin
          nxt_cur.state = IMP_ST_DONE;
        end
      end
      IMP_ST_DONE: begin
        nxt_cur.state = IMP_ST_IDLE;
        if (cur_ff.to_gpr) begin
          // Product registers are left untouched here
          nxt_cur.wb_valid = 1'b1;
          nxt_cur.wb_index = cur_ff.dest;
          nxt_cur.wb_data = cur_ff.prod[31:0];
        end else begin
          nxt_cur.bottom = cur_ff.prod[31:0];
          nxt_cur.upper = cur_ff.prod[63:32];
        end
      end
      default: nxt_cur.state = IMP_ST_IDLE;
    endcase
    busy_nxt = (nxt_cur.state != IMP_ST_IDLE);
    // Any dependent instruction waits; so does any unit op while busy, product-register reads included
    hazard = busy_nxt && issue_valid &&
             ((nxt_cur.to_gpr && (check_src_a == nxt_cur.dest || check_src_b == nxt_cur.dest))
              || op != IMP_OP_NONE);
    nxt_cur.stall = hazard;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign issue_stall = cur_ff.stall;
  assign wb_valid = cur_ff.wb_valid;
  assign wb_index = cur_ff.wb_index;
  assign wb_data = cur_ff.wb_data;
  assign upper_product_reg = cur_ff.upper;
  assign bottom_product_reg = cur_ff.bottom;
  assign arith_exc = 1'b0;

  property p_done_writes_wide;
    @(posedge core_clk) disable iff (!rst_b)
      (cur_ff.state == IMP_ST_DONE && !cur_ff.to_gpr) |=>
        (bottom_product_reg == $past(cur_ff.prod[31:0]) && upper_product_reg == $past(cur_ff.prod[63:32]));
  endproperty
  a_done_writes_wide: assert property (p_done_writes_wide) else $error("wide product not stored");

  property p_gpr_wb;
    @(posedge core_clk) disable iff (!rst_b)
      (cur_ff.state == IMP_ST_DONE && cur_ff.to_gpr) |=> (wb_valid && wb_index == $past(cur_ff.dest));
  endproperty
  a_gpr_wb: assert property (p_gpr_wb) else $error("register product not written back");

  property p_no_exc;
    @(posedge core_clk) disable iff (!rst_b) !arith_exc;
  endproperty
  a_no_exc: assert property (p_no_exc) else $error("arithmetic exception raised");

  sequence s_mul_start;
    cur_ff.state == IMP_ST_IDLE ##1 cur_ff.state == IMP_ST_BUSY;
  endsequence

  property p_busy_len;
    @(posedge core_clk) disable iff (!rst_b)
      s_mul_start |-> ##[15:16] cur_ff.state == IMP_ST_DONE;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("multiply latency wrong");

  property p_wr_bottom;
    @(posedge core_clk) disable iff (!rst_b)
      (issue_valid && !issue_stall && cur_ff.state == IMP_ST_IDLE && op == IMP_OP_WR_BOTTOM)
        |=> bottom_product_reg == $past(operand_one_val);
  endproperty
  a_wr_bottom: assert property (p_wr_bottom) else $error("bottom write lost");

  property p_wr_upper;
    @(posedge core_clk) disable iff (!rst_b)
      (issue_valid && !issue_stall && cur_ff.state == IMP_ST_IDLE && op == IMP_OP_WR_UPPER)
        |=> upper_product_reg == $past(operand_one_val);
  endproperty
  a_wr_upper: assert property (p_wr_upper) else $error("upper write lost");

  property p_rd_upper;
    @(posedge core_clk) disable iff (!rst_b)
      (issue_valid && !issue_stall && cur_ff.state == IMP_ST_IDLE && op == IMP_OP_RD_UPPER)
        |=> (wb_valid && wb_data == $past(upper_product_reg));
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read wrong");

  property p_busy_stalls;
    @(posedge core_clk) disable iff (!rst_b)
      (cur_ff.state == IMP_ST_BUSY && issue_valid &&
       (op == IMP_OP_RD_BOTTOM || op == IMP_OP_RD_UPPER)) |=> issue_stall;
  endproperty
  a_busy_stalls: assert property (p_busy_stalls) else $error("read not stalled");
endmodule
`default_nettype wire

// >>> tb/imp_regfile_model.sv
// General register file model fed by the unit's write-back port
`timescale 1ns/1ps
`default_nettype none
module imp_regfile_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic wb_valid,
  input wire logic [4:0] wb_index,
  input wire logic [31:0] wb_data
);
  logic [31:0] regs [32];
  // Results reach the file only through the one-cycle pulse
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 32; i++) begin
        regs[i] <= 32'h0000_0000;
      end
    end else if (wb_valid) begin
      regs[wb_index] <= wb_data;
    end
  end
endmodule
`default_nettype wire

// >>> tb/integer_multiply_product_regs_tb_top.sv
// Self-checking bench for the integer multiply unit
`include "imp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module integer_multiply_product_regs_tb_top;
  logic core_clk = 1'b0, rst_b = 1'b0, issue_valid = 1'b0, wb_valid, arith_exc, issue_stall;
  logic [31:0] issue_instr = 0, op_a = 0, op_b = 0, wb_data, upper_q, bottom_q;
  logic [4:0] src_a = 0, src_b = 0, wb_index;
  int n_errors = 0, n_checks = 0;
  imp_mul_unit i_dut (.core_clk(core_clk), .rst_b(rst_b), .issue_valid(issue_valid),
    .issue_instr(issue_instr), .operand_one_val(op_a), .operand_two_val(op_b),
    .check_src_a(src_a), .check_src_b(src_b), .issue_stall(issue_stall),
    .wb_valid(wb_valid), .wb_index(wb_index), .wb_data(wb_data),
    .upper_product_reg(upper_q), .bottom_product_reg(bottom_q), .arith_exc(arith_exc));
  imp_regfile_model i_regs (.core_clk(core_clk), .rst_b(rst_b), .wb_valid(wb_valid),
    .wb_index(wb_index), .wb_data(wb_data));
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  task give_verdict;
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] axf(input logic [9:0] mn, input logic [4:0] h, l);
    return {`IMP_MAJOR_GROUP_A, h, l, mn, `IMP_EXT_FUNC_GROUP};
  endfunction
  // Reads hold the offer through stalls and leave it up for the next call
  task automatic issue(input logic [31:0] ins, a, b, input logic [4:0] sa, input bit hold);
    int n;
    n = 0;
    issue_instr = ins;
    op_a = a;
    op_b = b;
    src_a = sa;
    if (issue_valid !== 1'b1) begin
      issue_valid = 1'b1;
    end
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (hold && wb_valid !== 1'b1 && n < 60);
    if (n >= 60) begin
      n_errors++;
      give_verdict();
    end
    // Idle edge so the strobe never drops and rises in one step
    if (!hold) begin
      issue_valid = 1'b0;
      @(posedge core_clk);
      #1;
    end
  endtask
  task automatic rd_chk(input bit up, input logic [31:0] ex);
    issue(axf(up ? `IMP_MINOR_RD_UPPER : `IMP_MINOR_RD_BOTTOM, 5'd9, 5'd0), 0, 0, 5'd0, 1);
    `CHK("read data", ex, wb_data)
    `CHK("read index", 5'd9, wb_index)
  endtask
  task automatic t_moves;
    issue(axf(`IMP_MINOR_WR_BOTTOM, 5'd0, 5'd4), 32'h1234_5678, 0, 5'd4, 0);
    issue(axf(`IMP_MINOR_WR_UPPER, 5'd0, 5'd5), 32'hCAFE_0001, 0, 5'd5, 0);
    rd_chk(1, 32'hCAFE_0001);
    issue(axf(`IMP_MINOR_WR_UPPER, 5'd0, 5'd5), 32'h0BAD_F00D, 0, 5'd5, 0);
    rd_chk(1, 32'h0BAD_F00D);
    rd_chk(0, 32'h1234_5678);
    `CHK("upper port", 32'h0BAD_F00D, upper_q)
  endtask
  // Read follows at once, so the stall path is exercised every time
  task automatic t_wide(input bit uns, input logic [31:0] a, b);
    logic [63:0] p;
    p = {{32{a[31] & ~uns}}, a} * {{32{b[31] & ~uns}}, b};
    // Shorter operand goes in operand two; result read before any write
    issue(axf(uns ? `IMP_MINOR_UNS_WIDE : `IMP_MINOR_SGN_WIDE, 5'd2, 5'd3), a, b, 5'd2, 0);
    rd_chk(1, p[63:32]);
    rd_chk(0, p[31:0]);
    `CHK("bottom port", p[31:0], bottom_q)
  endtask
  task automatic t_prod;
    int n;
    n = 0;
    issue({6'h00, 5'd3, 5'd2, 5'd7, 1'b0, `IMP_MINOR_PROD_REG}, 32'hFFFF_FFF9, 32'h6, 5'd2, 0);
    // Unrelated op that reads the pending destination must be held off
    issue_instr = 32'h0000_0000;
    src_a = 5'd7;
    issue_valid = 1'b1;
    @(posedge core_clk);
    #1;
    `CHK("dependent stall", 1'b1, issue_stall)
    while (wb_valid !== 1'b1 && n < 60) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 60) begin
      n_errors++;
      give_verdict();
    end
    `CHK("stall released", 1'b0, issue_stall)
    `CHK("product low word", 32'hFFFF_FFD6, wb_data)
    `CHK("product index", 5'd7, wb_index)
    issue_valid = 1'b0;
    @(posedge core_clk);
    #1;
    `CHK("register file", 32'hFFFF_FFD6, i_regs.regs[7])
  endtask
  always @(negedge core_clk) begin
    if (rst_b) begin
      `CHK("exception flag", 1'b0, arith_exc)
    end
  end
  initial begin
    repeat (10) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    `CHK("upper reset", `IMP_PROD_RST, upper_q)
    `CHK("bottom reset", `IMP_PROD_RST, bottom_q)
    t_moves();
    t_wide(0, 32'hFFFF_FFFD, 32'h0000_0005);
    t_wide(0, 32'h8000_0000, 32'h8000_0000);
    t_wide(0, 32'h7FFF_FFFF, 32'hFFFF_FFFF);
    t_wide(1, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
    t_wide(1, 32'h8000_0000, 32'h0000_0002);
    t_prod();
    t_wide(1, 32'h0001_0000, 32'h0001_0000);
    give_verdict();
  end
endmodule
`default_nettype wire
